// ---- hw/flc_seq.v ----
// host controller that sequences lock, unlock and protection program commands
`timescale 1ns/100ps
`default_nettype none

`include "flc_defines.vh"

// How it works
// - protection program: C0H then data at location
// - enables toggle between every status read
// - errors must be cleared before further operations; the code refuses only lock, unlock and program, array and reset still run
// - full status check may follow several operations
// - write FFH after operation for array mode
module flc_seq #(
	parameter AW         = 24,
	parameter DW         = 8,
	parameter POLL_LIMIT = `FLC_POLL_LIMIT,
	parameter RECOV_CYC  = `FLC_RECOV_CYC
) (
	input  wire          core_clk_i,
	input  wire          sys_rst_i,
	input  wire [3:0]    avs_address_i,
	input  wire          avs_read_i,
	input  wire          avs_write_i,
	input  wire [31:0]   avs_writedata_i,
	output reg  [31:0]   avs_readdata_o,
	output reg           avs_waitrequest_o,
	output wire [AW-1:0] fl_addr_o,
	output wire          fl_ce_n_o,
	output wire          fl_oe_n_o,
	output wire          fl_we_n_o,
	output reg           fl_rst_n_o,
	input  wire [DW-1:0] fl_dq_i,
	output wire [DW-1:0] fl_dq_o,
	output wire          fl_dq_oe_n_o,
	input  wire          fl_sts_i
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	localparam [2:0] S_IDLE  = 3'h0;
	localparam [2:0] S_CMD1  = 3'h1;
	localparam [2:0] S_CMD2  = 3'h2;
	localparam [2:0] S_POLL  = 3'h3;
	localparam [2:0] S_ARRAY = 3'h4;
	localparam [2:0] S_RST   = 3'h5;
	localparam [2:0] S_RECOV = 3'h6;
	// the pin falls one edge after entry, so count one extra to keep the full width
	localparam [31:0] RST_LAST   = `FLC_RESET_CYC;
	localparam [31:0] RECOV_LAST = RECOV_CYC - 1;
	localparam [31:0] POLL_LAST  = POLL_LIMIT - 1;

	reg  [2:0]    state_q;
	reg  [2:0]    op_q;
	reg           launched_q;
	reg  [31:0]   cnt_q;
	reg  [AW-1:0] addr_q;
	reg  [DW-1:0] data_q;
	reg  [7:0]    sr_q;
	reg           done_q;
	reg           refused_q;
	reg           timeout_q;
	reg           array_q;
	reg           sts_q;
	reg           cyc_start_q;
	reg           cyc_write_q;
	reg  [AW-1:0] cyc_addr_q;
	reg  [DW-1:0] cyc_data_q;
	wire          cyc_done;
	wire [DW-1:0] cyc_rdata;
	wire          acc;
	wire          ctrl_wr;
	wire [2:0]    new_op;
	wire          err_pending;
	wire          op_refused;
	wire          set_done;
	wire [7:0]    rd_byte;

	assign acc      = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
	assign ctrl_wr  = acc & avs_write_i & (avs_address_i == `FLC_REG_CTRL);
	assign new_op   = avs_writedata_i[`FLC_CTRL_OP_MSB:`FLC_CTRL_OP_LSB];
	assign rd_byte  = cyc_rdata[7:0]; // status byte sits in the low lane
	// sticky device errors left from earlier operations
	assign err_pending = |(sr_q & `FLC_SR_ERR_MASK);
	// a new lock, unlock or program is refused until clear-status or a reset
	assign op_refused  = ((new_op == `FLC_OP_LOCK) | (new_op == `FLC_OP_UNLOCK)
		| (new_op == `FLC_OP_OTP)) & err_pending;
	assign set_done = ((state_q == S_ARRAY) & launched_q & cyc_done)
		| ((state_q == S_CMD1) & launched_q & cyc_done
			& ((op_q == `FLC_OP_CLRSR) | (op_q == `FLC_OP_ARRAY)))
		| ((state_q == S_RECOV) & (cnt_q == RECOV_LAST));

	// ------------------------------------------------------------
	// flash pin cycle engine
	// ------------------------------------------------------------
	flc_bus_cycle #(
		.AW (AW),
		.DW (DW)
	) u_cycle (
		.core_clk_i   (core_clk_i),
		.sys_rst_i    (sys_rst_i),
		.start_i      (cyc_start_q),
		.is_write_i   (cyc_write_q),
		.addr_i       (cyc_addr_q),
		.wdata_i      (cyc_data_q),
		.done_o       (cyc_done),
		.rdata_o      (cyc_rdata),
		.fl_addr_o    (fl_addr_o),
		.fl_ce_n_o    (fl_ce_n_o),
		.fl_oe_n_o    (fl_oe_n_o),
		.fl_we_n_o    (fl_we_n_o),
		.fl_dq_i      (fl_dq_i),
		.fl_dq_o      (fl_dq_o),
		.fl_dq_oe_n_o (fl_dq_oe_n_o)
	);

	// ------------------------------------------------------------
	// avalon slave: one wait cycle, then answer
	// ------------------------------------------------------------
	always @(posedge core_clk_i)
	begin
		if (sys_rst_i)
		begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o    <= 32'h00000000;
			addr_q            <= {AW{1'b0}};
			data_q            <= {DW{1'b0}};
		end
		else
		begin
			avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
			if (acc & avs_write_i & (avs_address_i == `FLC_REG_ADDR))
				addr_q <= avs_writedata_i[AW-1:0];
			if (acc & avs_write_i & (avs_address_i == `FLC_REG_DATA))
				data_q <= avs_writedata_i[DW-1:0];
			case (avs_address_i)
			`FLC_REG_ADDR: avs_readdata_o <= {{(32-AW){1'b0}}, addr_q};
			`FLC_REG_DATA: avs_readdata_o <= {{(32-DW){1'b0}}, data_q};
			`FLC_REG_STAT: avs_readdata_o <= {18'h00000, sts_q, array_q, timeout_q,
				refused_q, done_q, (state_q != S_IDLE), sr_q};
			default:       avs_readdata_o <= 32'h00000000; // ctrl and unmapped
			endcase
		end
	end

	// ------------------------------------------------------------
	// status flags; a completion in the same cycle beats the clear
	// ------------------------------------------------------------
	always @(posedge core_clk_i)
	begin
		if (sys_rst_i)
		begin
			done_q    <= 1'b0;
			refused_q <= 1'b0;
			sts_q     <= 1'b1;
		end
		else
		begin
			// completion pin level, low while busy, floats high otherwise
			sts_q <= fl_sts_i;
			if (set_done)
				done_q <= 1'b1;
			else if (ctrl_wr)
				done_q <= 1'b0;
			if (ctrl_wr)
				refused_q <= op_refused
					| ((state_q != S_IDLE) & (new_op != `FLC_OP_NONE));
		end
	end

	// ------------------------------------------------------------
	// operation sequencer
	// ------------------------------------------------------------
	always @(posedge core_clk_i)
	begin
		cyc_start_q <= 1'b0;
		if (sys_rst_i)
		begin
			state_q     <= S_IDLE;
			op_q        <= `FLC_OP_NONE;
			launched_q  <= 1'b0;
			cnt_q       <= 32'h00000000;
			sr_q        <= 8'h80;
			timeout_q   <= 1'b0;
			array_q     <= 1'b1;
			fl_rst_n_o  <= 1'b1;
			cyc_write_q <= 1'b0;
			cyc_addr_q  <= {AW{1'b0}};
			cyc_data_q  <= {DW{1'b0}};
		end
		else
		begin
			case (state_q)
			S_IDLE:
			begin
				if (ctrl_wr & ~op_refused & (new_op != `FLC_OP_NONE))
				begin
					op_q      <= new_op;
					timeout_q <= 1'b0;
					cnt_q     <= 32'h00000000;
					state_q   <= (new_op == `FLC_OP_RESET) ? S_RST : S_CMD1;
				end
			end
			S_CMD1:
			begin
				if (~launched_q)
				begin
					cyc_start_q <= 1'b1;
					cyc_write_q <= 1'b1;
					cyc_addr_q  <= addr_q; // block address for lock
					launched_q  <= 1'b1;
					case (op_q)
					`FLC_OP_OTP:   cyc_data_q <= `FLC_CMD_OTP_SETUP;
					`FLC_OP_CLRSR: cyc_data_q <= `FLC_CMD_CLR_STATUS;
					`FLC_OP_ARRAY: cyc_data_q <= `FLC_CMD_ARRAY;
					default:       cyc_data_q <= `FLC_CMD_LOCK_SETUP;
					endcase
				end
				else if (cyc_done)
				begin
					launched_q <= 1'b0;
					if (op_q == `FLC_OP_CLRSR)
					begin
						sr_q    <= 8'h80; // sticky errors leave here and at the end of a reset
						array_q <= 1'b0;
						state_q <= S_IDLE;
					end
					else if (op_q == `FLC_OP_ARRAY)
					begin
						array_q <= 1'b1;
						state_q <= S_IDLE;
					end
					else
						state_q <= S_CMD2;
				end
			end
			S_CMD2:
			begin
				if (~launched_q)
				begin
					cyc_start_q <= 1'b1;
					launched_q  <= 1'b1;
					array_q     <= 1'b0;
					case (op_q)
					`FLC_OP_LOCK:   cyc_data_q <= `FLC_CMD_LOCK_CONF;
					`FLC_OP_UNLOCK: cyc_data_q <= `FLC_CMD_CLR_CONF;
					default:        cyc_data_q <= data_q; // data at location
					endcase
				end
				else if (cyc_done)
				begin
					launched_q <= 1'b0;
					cnt_q      <= 32'h00000000;
					state_q    <= S_POLL;
				end
			end
			S_POLL:
			begin
				// only status reads go out while the engine is busy
				if (~launched_q)
				begin
					cyc_start_q <= 1'b1;
					cyc_write_q <= 1'b0;
					launched_q  <= 1'b1;
				end
				else if (cyc_done)
				begin
					launched_q <= 1'b0;
					cnt_q      <= cnt_q + 32'h00000001;
					if (rd_byte[`FLC_SR_READY])
					begin
						// keep fail, voltage and protect bits for decoding
						sr_q    <= rd_byte | (sr_q & `FLC_SR_ERR_MASK);
						state_q <= S_ARRAY;
					end
					else if (cnt_q == POLL_LAST)
					begin
						timeout_q <= 1'b1;
						sr_q      <= rd_byte | (sr_q & `FLC_SR_ERR_MASK);
						state_q   <= S_ARRAY;
					end
				end
			end
			S_ARRAY:
			begin
				// return the device to array reads once the operation ends
				if (~launched_q)
				begin
					cyc_start_q <= 1'b1;
					cyc_write_q <= 1'b1;
					cyc_data_q  <= `FLC_CMD_ARRAY;
					launched_q  <= 1'b1;
				end
				else if (cyc_done)
				begin
					launched_q <= 1'b0;
					array_q    <= 1'b1;
					state_q    <= S_IDLE;
				end
			end
			S_RST:
			begin
				// reset pin low aborts work and clears the device status
				fl_rst_n_o <= 1'b0;
				cnt_q      <= cnt_q + 32'h00000001;
				if (cnt_q == RST_LAST)
				begin
					fl_rst_n_o <= 1'b1;
					cnt_q      <= 32'h00000000;
					state_q    <= S_RECOV;
				end
			end
			S_RECOV:
			begin
				cnt_q <= cnt_q + 32'h00000001;
				if (cnt_q == RECOV_LAST)
				begin
					sr_q    <= 8'h80;
					array_q <= 1'b1;
					state_q <= S_IDLE;
				end
			end
			default:
				state_q <= S_IDLE;
			endcase
		end
	end

endmodule

`default_nettype wire

// ---- hw/flc_defines.vh ----
// constants of the lock, unlock and protection-program sequencer
`ifndef FLC_DEFINES_VH
`define FLC_DEFINES_VH

// ----------------------------------------------------------------
// avalon register offsets (byte addresses)
// ----------------------------------------------------------------
`define FLC_REG_CTRL      4'h0
`define FLC_REG_ADDR      4'h4
`define FLC_REG_DATA      4'h8
`define FLC_REG_STAT      4'hC

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define FLC_CTRL_OP_LSB   0
`define FLC_CTRL_OP_MSB   2
`define FLC_OP_NONE       3'h0
`define FLC_OP_LOCK       3'h1
`define FLC_OP_UNLOCK     3'h2
`define FLC_OP_OTP        3'h3
`define FLC_OP_CLRSR      3'h4
`define FLC_OP_ARRAY      3'h5
`define FLC_OP_RESET      3'h6

// ----------------------------------------------------------------
// host status register fields
// ----------------------------------------------------------------
`define FLC_ST_BYTE_LSB   0
`define FLC_ST_BYTE_MSB   7
`define FLC_ST_BUSY       8
`define FLC_ST_DONE       9
`define FLC_ST_REFUSED    10
`define FLC_ST_TIMEOUT    11
`define FLC_ST_ARRAY      12
`define FLC_ST_PIN        13

// ----------------------------------------------------------------
// flash command bytes and device status bits
// ----------------------------------------------------------------
`define FLC_CMD_LOCK_SETUP 8'h60
`define FLC_CMD_LOCK_CONF  8'h01
`define FLC_CMD_CLR_CONF   8'hD0
`define FLC_CMD_OTP_SETUP  8'hC0
`define FLC_CMD_CLR_STATUS 8'h50
`define FLC_CMD_ARRAY      8'hFF
`define FLC_SR_READY      7
`define FLC_SR_ERASE_FAIL 5
`define FLC_SR_PROG_FAIL  4
`define FLC_SR_VOLT_LOW   3
`define FLC_SR_PROTECTED  1
`define FLC_SR_ERR_MASK   8'h3A

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FLC_CLK_NS        4
`define FLC_T_STROBE_NS   120
`define FLC_T_RESET_NS    100
`define FLC_T_RECOV_NS    1000
`define FLC_STROBE_CYC    ((`FLC_T_STROBE_NS + `FLC_CLK_NS - 1) / `FLC_CLK_NS)
`define FLC_RESET_CYC     ((`FLC_T_RESET_NS + `FLC_CLK_NS - 1) / `FLC_CLK_NS)
`define FLC_RECOV_CYC     ((`FLC_T_RECOV_NS + `FLC_CLK_NS - 1) / `FLC_CLK_NS)
`define FLC_POLL_LIMIT    100000

`endif

// ---- hw/flc_bus_cycle.v ----
// one asynchronous write or read cycle on the flash pins
`timescale 1ns/100ps
`default_nettype none

`include "flc_defines.vh"

module flc_bus_cycle #(
	parameter AW = 24,
	parameter DW = 8
) (
	input  wire          core_clk_i,
	input  wire          sys_rst_i,
	input  wire          start_i,
	input  wire          is_write_i,
	input  wire [AW-1:0] addr_i,
	input  wire [DW-1:0] wdata_i,
	output reg           done_o,
	output reg  [DW-1:0] rdata_o,
	output reg  [AW-1:0] fl_addr_o,
	output reg           fl_ce_n_o,
	output reg           fl_oe_n_o,
	output reg           fl_we_n_o,
	input  wire [DW-1:0] fl_dq_i,
	output reg  [DW-1:0] fl_dq_o,
	output reg           fl_dq_oe_n_o
);

	localparam [1:0] PH_IDLE   = 2'h0;
	localparam [1:0] PH_SETUP  = 2'h1;
	localparam [1:0] PH_STROBE = 2'h2;
	localparam [1:0] PH_HOLD   = 2'h3;
	localparam [31:0] STROBE_CYC  = `FLC_STROBE_CYC;
	localparam [7:0]  STROBE_LAST = STROBE_CYC[7:0] - 8'h01;

	reg [1:0] phase_q;
	reg [7:0] cnt_q;
	reg       wr_q;

	// ------------------------------------------------------------
	// cycle sequencer: setup, strobe, hold, then all strobes high
	// ------------------------------------------------------------
	// every cycle ends with ce and oe released, so back-to-back status
	// reads always toggle the enables and refresh the status byte
	always @(posedge core_clk_i)
	begin
		done_o <= 1'b0;
		if (sys_rst_i)
		begin
			phase_q      <= PH_IDLE;
			cnt_q        <= 8'h00;
			wr_q         <= 1'b0;
			rdata_o      <= {DW{1'b0}};
			fl_addr_o    <= {AW{1'b0}};
			fl_ce_n_o    <= 1'b1;
			fl_oe_n_o    <= 1'b1;
			fl_we_n_o    <= 1'b1;
			fl_dq_o      <= {DW{1'b0}};
			fl_dq_oe_n_o <= 1'b1;
		end
		else
		begin
			case (phase_q)
			PH_IDLE:
			begin
				if (start_i)
				begin
					wr_q         <= is_write_i;
					fl_addr_o    <= addr_i;
					fl_dq_o      <= wdata_i;
					fl_dq_oe_n_o <= ~is_write_i;
					fl_ce_n_o    <= 1'b0;
					phase_q      <= PH_SETUP;
				end
			end
			PH_SETUP:
			begin
				fl_we_n_o <= ~wr_q;
				fl_oe_n_o <= wr_q;
				cnt_q     <= 8'h00;
				phase_q   <= PH_STROBE;
			end
			PH_STROBE:
			begin
				if (cnt_q == STROBE_LAST)
				begin
					rdata_o   <= fl_dq_i; // sampled at end of access time
					fl_we_n_o <= 1'b1;
					fl_oe_n_o <= 1'b1;
					phase_q   <= PH_HOLD;
				end
				else
					cnt_q <= cnt_q + 8'h01;
			end
			PH_HOLD:
			begin
				fl_ce_n_o    <= 1'b1;
				fl_dq_oe_n_o <= 1'b1;
				done_o       <= 1'b1;
				phase_q      <= PH_IDLE;
			end
			default:
				phase_q <= PH_IDLE;
			endcase
		end
	end

endmodule

`default_nettype wire

// ---- verification/flc_seq_checker.sv ----
// concurrent checks on the avalon bus and flash pins of the sequencer
`timescale 1ns/100ps
`default_nettype none
module flc_seq_checker #(
	parameter AW = 24,
	parameter DW = 8
) (
	input wire logic          core_clk_i,
	input wire logic          sys_rst_i,
	input wire logic          avs_read_i,
	input wire logic          avs_write_i,
	input wire logic          avs_waitrequest_o,
	input wire logic [AW-1:0] fl_addr_o,
	input wire logic          fl_ce_n_o,
	input wire logic          fl_oe_n_o,
	input wire logic          fl_we_n_o,
	input wire logic          fl_rst_n_o,
	input wire logic [DW-1:0] fl_dq_o,
	input wire logic          fl_dq_oe_n_o
);
	logic [5:0] stb_q;
	logic [5:0] rlo_q;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	// widths of the current strobe and of the reset pulse
	always_ff @(posedge core_clk_i)
	begin
		stb_q <= (sys_rst_i || (fl_we_n_o && fl_oe_n_o)) ? 6'h00 : stb_q + 6'h01;
		rlo_q <= (sys_rst_i || fl_rst_n_o) ? 6'h00 : rlo_q + 6'h01;
	end
	// --------------------------------------------------------------
	// properties
	// --------------------------------------------------------------
	sequence s_open;
		$fell(fl_ce_n_o);
	endsequence
	sequence s_strobe;
		$fell(fl_we_n_o) || $fell(fl_oe_n_o);
	endsequence
	property p_wait_one;
		(avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
	endproperty
	property p_wait_pulse;
		$fell(avs_waitrequest_o) |=> avs_waitrequest_o;
	endproperty
	property p_open_strobe;
		s_open |=> s_strobe;
	endproperty
	property p_strobe_len;
		$rose(fl_we_n_o) || $rose(fl_oe_n_o) |-> stb_q == 6'h1E;
	endproperty
	property p_ce_gate;
		fl_ce_n_o |-> fl_we_n_o && fl_oe_n_o;
	endproperty
	property p_no_fight;
		!fl_oe_n_o |-> fl_dq_oe_n_o && fl_we_n_o;
	endproperty
	property p_wr_hold;
		!fl_we_n_o |-> !fl_dq_oe_n_o && $stable(fl_addr_o) && $stable(fl_dq_o);
	endproperty
	property p_gap;
		$rose(fl_ce_n_o) |=> fl_ce_n_o;
	endproperty
	property p_rst_len;
		$rose(fl_rst_n_o) |-> rlo_q == 6'h19;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("no answer one cycle after request");
	a_wait_pulse: assert property (p_wait_pulse) else $error("wait low for over a cycle");
	a_open_strobe: assert property (p_open_strobe) else $error("strobe late after select");
	a_strobe_len: assert property (p_strobe_len) else $error("strobe width wrong");
	a_ce_gate: assert property (p_ce_gate) else $error("strobe without select");
	a_no_fight: assert property (p_no_fight) else $error("data bus contention");
	a_wr_hold: assert property (p_wr_hold) else $error("write data moved in strobe");
	a_gap: assert property (p_gap) else $error("no idle between cycles");
	a_rst_len: assert property (p_rst_len) else $error("reset pulse width wrong");
endmodule
bind flc_seq flc_seq_checker #(.AW(AW), .DW(DW)) flc_seq_checker_i (
	.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
	.fl_addr_o(fl_addr_o), .fl_ce_n_o(fl_ce_n_o), .fl_oe_n_o(fl_oe_n_o),
	.fl_we_n_o(fl_we_n_o), .fl_rst_n_o(fl_rst_n_o), .fl_dq_o(fl_dq_o),
	.fl_dq_oe_n_o(fl_dq_oe_n_o)
);
`default_nettype wire

// ---- verification/flc_flash_model.sv ----
// behavioural flash device answering lock, unlock and protection commands
`timescale 1ns/100ps
`default_nettype none
module flc_flash_model #(
	parameter [23:0] OTP_LO = 24'h000080,
	parameter [23:0] OTP_HI = 24'h000090
) (
	input  wire logic        clk_i,
	input  wire logic [23:0] addr_i,
	input  wire logic        ce_n_i,
	input  wire logic        oe_n_i,
	input  wire logic        we_n_i,
	input  wire logic        rst_n_i,
	input  wire logic [7:0]  dq_i,
	output logic      [7:0]  dq_o,
	output logic             sts_o,
	input  wire logic [15:0] busy_len_i,
	input  wire logic        vlow_i,
	input  wire logic        fail_i
);
	logic [7:0]  sr_q = 8'h00;
	logic [7:0]  pend_q = 8'h00;
	logic [7:0]  lat_q = 8'h00;
	logic [15:0] busy_q = 16'h0000;
	logic        stat_q = 1'h0; // array mode at power-up
	logic        we_q = 1'h1;
	logic        oe_q = 1'h1;
	wire  [7:0]  out_w = stat_q ? {busy_q == 16'h0000, sr_q[6:0]} : addr_i[7:0] ^ 8'h5A;
	// value latched at each fall of output enable, inverted once released
	assign dq_o = (!ce_n_i && !oe_n_i) ? lat_q : ~lat_q;
	// pin sinks while the engine runs, floats to the pull-up otherwise
	assign sts_o = !rst_n_i || busy_q == 16'h0000;
	// command decode at each rising write strobe while out of reset and not busy
	always @(posedge clk_i)
	begin
		we_q <= we_n_i;
		oe_q <= oe_n_i;
		if (!oe_n_i && oe_q)
			lat_q <= out_w;
		if (!rst_n_i)
		begin
			sr_q <= 8'h00;
			stat_q <= 1'h0;
			busy_q <= 16'h0000;
			pend_q <= 8'h00;
		end
		else if (busy_q != 16'h0000)
			busy_q <= busy_q - 16'h0001;
		else if (we_n_i && !we_q && !ce_n_i)
		begin
			stat_q <= dq_i != 8'hFF || pend_q != 8'h00;
			pend_q <= (pend_q == 8'h00 && (dq_i == 8'h60 || dq_i == 8'hC0)) ? dq_i : 8'h00;
			if (pend_q == 8'h60 && (dq_i == 8'h01 || dq_i == 8'hD0))
			begin
				busy_q <= busy_len_i;
				sr_q <= sr_q | (vlow_i ? 8'h08 : !fail_i ? 8'h00 : dq_i[0] ? 8'h10 : 8'h20);
			end
			else if (pend_q == 8'h60)
				sr_q <= sr_q | 8'h30;
			else if (pend_q == 8'hC0)
			begin
				busy_q <= busy_len_i;
				if (sr_q[3] || vlow_i)
					sr_q <= sr_q | 8'h18;
				else if (addr_i < OTP_LO || addr_i >= OTP_HI || fail_i)
					sr_q <= sr_q | 8'h10;
			end
			else if (dq_i == 8'h50)
				sr_q <= 8'h00;
		end
	end
endmodule
`default_nettype wire

// ---- verification/test_flc_seq.sv ----
// self-checking bench of the flash command sequencer
`timescale 1ns/100ps
`default_nettype none
`include "flc_defines.vh"
module test_flc_seq;
	logic        core_clk_i;
	logic        sys_rst_i;
	logic [3:0]  avs_address_i;
	logic        avs_read_i;
	logic        avs_write_i;
	logic [31:0] avs_writedata_i;
	logic [31:0] avs_readdata_o;
	logic        avs_waitrequest_o;
	logic [23:0] fl_addr_o;
	logic [7:0]  fl_dq_o, dq_w, mdl_dq;
	logic        fl_ce_n_o, fl_oe_n_o, fl_we_n_o, fl_rst_n_o, fl_dq_oe_n_o, sts;
	logic [15:0] busy_len;
	logic        vlow, fail;
	logic        we_q = 1'h1;
	logic [31:0] rd, seed_q, log_q[$];
	int          bad_count, num_checks, cyc, i;
	assign dq_w = fl_dq_oe_n_o ? mdl_dq : fl_dq_o;
	flc_seq #(.POLL_LIMIT(8), .RECOV_CYC(4)) flc_seq_i (
		.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.fl_addr_o(fl_addr_o), .fl_ce_n_o(fl_ce_n_o), .fl_oe_n_o(fl_oe_n_o),
		.fl_we_n_o(fl_we_n_o), .fl_rst_n_o(fl_rst_n_o), .fl_dq_i(dq_w), .fl_dq_o(fl_dq_o),
		.fl_dq_oe_n_o(fl_dq_oe_n_o), .fl_sts_i(sts)
	);
	flc_flash_model flc_flash_model_i (
		.clk_i(core_clk_i), .addr_i(fl_addr_o), .ce_n_i(fl_ce_n_o), .oe_n_i(fl_oe_n_o),
		.we_n_i(fl_we_n_o), .rst_n_i(fl_rst_n_o), .dq_i(dq_w), .dq_o(mdl_dq), .sts_o(sts),
		.busy_len_i(busy_len), .vlow_i(vlow), .fail_i(fail)
	);
	// clock, cycle ceiling and flash write log
	initial
	begin
		core_clk_i = 1'h0;
		forever #2 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i)
	begin
		cyc++;
		we_q <= fl_we_n_o;
		if (fl_we_n_o && !we_q)
			log_q.push_back({fl_addr_o, fl_dq_o});
		if (cyc == 60000)
		begin
			bad_count++;
			summarize();
		end
	end
	// --------------------------------------------------------------
	// tasks and expectations
	// --------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	function automatic logic [7:0] exp_sr(input logic [2:0] o, input logic v, f,
		input logic [23:0] a);
		if (o == `FLC_OP_UNLOCK)
			return v ? 8'h08 : f ? 8'h20 : 8'h00;
		if (o == `FLC_OP_OTP)
			return v ? 8'h18 : (a < 24'h80 || a >= 24'h90 || f) ? 8'h10 : 8'h00;
		return v ? 8'h08 : f ? 8'h10 : 8'h00;
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, s);
		num_checks++;
		if (s !== e)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		do
			@(posedge core_clk_i);
		while (avs_waitrequest_o !== 1'h0);
		rd = avs_readdata_o;
		avs_write_i <= 1'h0;
		avs_read_i <= 1'h0;
		@(posedge core_clk_i);
	endtask
	task automatic op(input logic [2:0] o);
		log_q.delete();
		bus(1'h1, `FLC_REG_CTRL, {29'h0, o});
		do
			bus(1'h0, `FLC_REG_STAT, 32'h0);
		while (rd[`FLC_ST_DONE] !== 1'h1);
	endtask
	task automatic run_case(input logic [2:0] o, input logic v, f, input logic [23:0] a,
		input logic [7:0] d);
		op(`FLC_OP_CLRSR);
		chk("clear", {24'h0, `FLC_CMD_CLR_STATUS}, {24'h0, log_q[0][7:0]});
		vlow <= v;
		fail <= f;
		bus(1'h1, `FLC_REG_ADDR, {8'h0, a});
		bus(1'h1, `FLC_REG_DATA, {24'h0, d});
		op(o);
		chk("setup", {24'h0, o == `FLC_OP_OTP ? 8'hC0 : 8'h60}, {24'h0, log_q[0][7:0]});
		chk("confirm", {a, o == `FLC_OP_OTP ? d : o == `FLC_OP_LOCK ? 8'h01 : 8'hD0}, log_q[1]);
		chk("array", {a, 8'hFF}, log_q[2]);
		chk("status", {24'h0, 8'h80 | exp_sr(o, v, f, a)}, {24'h0, rd[7:0]});
		chk("mode pin", 32'h3, {30'h0, rd[`FLC_ST_PIN], rd[`FLC_ST_ARRAY]});
		vlow <= 1'h0;
		fail <= 1'h0;
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// --------------------------------------------------------------
	// scenarios
	// --------------------------------------------------------------
	initial
	begin
		{sys_rst_i, avs_address_i, avs_read_i, avs_write_i, avs_writedata_i} = 39'h4000000000;
		{vlow, fail, busy_len} = 18'h00028;
		seed_q = 32'h00000020;
		repeat (16) @(posedge core_clk_i);
		sys_rst_i <= 1'h0;
		bus(1'h0, `FLC_REG_STAT, 32'h0);
		chk("reset stat", 32'h3080, rd & 32'h3DFF);
		bus(1'h1, `FLC_REG_ADDR, 32'h00ABCDEF);
		bus(1'h1, 4'h1, 32'h00123456);
		bus(1'h0, `FLC_REG_ADDR, 32'h0);
		chk("addr reg", 32'h00ABCDEF, rd & 32'h00FFFFFF);
		bus(1'h0, 4'h2, 32'h0);
		chk("unmapped", 32'h0, rd);
		run_case(`FLC_OP_OTP, 1'h0, 1'h0, 24'h00007F, 8'h3C);
		run_case(`FLC_OP_OTP, 1'h0, 1'h0, 24'h000080, 8'hC3);
		run_case(`FLC_OP_OTP, 1'h0, 1'h0, 24'h00008F, 8'h5A);
		run_case(`FLC_OP_OTP, 1'h0, 1'h0, 24'h000090, 8'hA5);
		for (i = 0; i < 10; i++)
		begin
			seed_q = xs(seed_q);
			busy_len <= 16'h0014 + {8'h0, seed_q[31:24]} % 16'h00B4;
			run_case(3'h1 + seed_q[2:0] % 3'h3, seed_q[8] & seed_q[9], seed_q[10] & seed_q[11],
				seed_q[12] ? {16'h0, 8'h78 + {3'h0, seed_q[20:16]}} : seed_q[31:8], seed_q[7:0]);
		end
		run_case(`FLC_OP_LOCK, 1'h1, 1'h0, 24'h020000, 8'h00);
		bus(1'h1, `FLC_REG_CTRL, {29'h0, `FLC_OP_UNLOCK});
		bus(1'h0, `FLC_REG_STAT, 32'h0);
		chk("sticky refuse", 32'h188, {23'h0, rd[`FLC_ST_REFUSED], rd[7:0]});
		op(`FLC_OP_CLRSR);
		bus(1'h1, `FLC_REG_CTRL, {29'h0, `FLC_OP_UNLOCK});
		bus(1'h1, `FLC_REG_CTRL, {29'h0, `FLC_OP_LOCK});
		bus(1'h0, `FLC_REG_STAT, 32'h0);
		chk("busy refuse", 32'h3, {30'h0, rd[`FLC_ST_REFUSED], rd[`FLC_ST_BUSY]});
		do
			bus(1'h0, `FLC_REG_STAT, 32'h0);
		while (rd[`FLC_ST_DONE] !== 1'h1);
		busy_len <= 16'h0800;
		vlow <= 1'h1;
		op(`FLC_OP_LOCK);
		chk("timeout", 32'h1, {31'h0, rd[`FLC_ST_TIMEOUT]});
		vlow <= 1'h0;
		busy_len <= 16'h0028;
		op(`FLC_OP_RESET);
		chk("after reset", 32'h1080, rd & 32'h10FF);
		run_case(`FLC_OP_LOCK, 1'h0, 1'h1, 24'h7E0000, 8'h00);
		summarize();
	end
endmodule
`default_nettype wire
